// >>> plf_bank.sv
`timescale 1ns/1ps
`default_nettype none
module plf_bank
  import plf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  plf_link_if.bank link,
  input wire logic comm_fault_clear,
  output logic comm_fault,
  output logic [15:0] ov_threshold,
  output logic ov_restart_en,
  output logic oc_restart_en,
  output logic ot_restart_en
);
  import plf_pkg::*;

  logic [15:0] work_reg [NSLOT];
  logic [15:0] nv_reg [NSLOT];
  // flash has no logic reset: only the first reset after power-up seeds it
  logic nv_valid_reg = 1'b0;
  logic dev_lock_reg;
  logic comm_fault_reg;
  logic ack_reg;
  logic nak_reg;
  logic [15:0] rdata_reg;

  // map command code onto a storage slot
  logic [3:0] slot;
  logic hit;
  always_comb begin
    hit = 1'b1;
    slot = SL_SETPOINT;
    unique case (link.code)
      CMD_SETPOINT: slot = SL_SETPOINT;
      CMD_MARGIN_HI: slot = SL_MARGIN_HI;
      CMD_MARGIN_LO: slot = SL_MARGIN_LO;
      CMD_INP_ON: slot = SL_INP_ON;
      CMD_INP_OFF: slot = SL_INP_OFF;
      CMD_CAL_GAIN: slot = SL_CAL_GAIN;
      CMD_CAL_OFFSET: slot = SL_CAL_OFFSET;
      CMD_OV_LIMIT: slot = SL_OV_LIMIT;
      CMD_OV_RESP: slot = SL_OV_RESP;
      CMD_OC_LIMIT: slot = SL_OC_LIMIT;
      CMD_OC_RESP: slot = SL_OC_RESP;
      CMD_OC_WARN: slot = SL_OC_WARN;
      CMD_OT_LIMIT: slot = SL_OT_LIMIT;
      CMD_OT_RESP: slot = SL_OT_RESP;
      CMD_OT_WARN: slot = SL_OT_WARN;
      CMD_TRIM_CFG: slot = SL_TRIM_CFG;
      default: hit = 1'b0;
    endcase
  end

  logic range_ok;
  plf_check u_check (
    .slot(slot),
    .val(link.wdata),
    .cur(work_reg),
    .ok(range_ok)
  );

  wire take = link.req && !ack_reg && !nak_reg;
  wire is_store = link.code == CMD_STORE_ALL;
  wire is_restore = link.code == CMD_RESTORE_ALL;
  wire is_devtype = link.code == CMD_DEV_TYPE;
  wire is_fmt = link.code == CMD_VOUT_FMT;
  wire trim_sel = work_reg[SL_TRIM_CFG][0];
  wire is_cal = slot == SL_CAL_GAIN || slot == SL_CAL_OFFSET;
  wire wr_blocked = (slot == SL_SETPOINT && trim_sel)
    || (is_cal && dev_lock_reg);
  wire wr_good = hit && range_ok && !wr_blocked;
  wire do_write = take && link.wr && wr_good;
  wire do_store = take && link.wr && is_store;
  wire do_restore = take && link.wr && is_restore;
  wire do_lock = take && link.wr && is_devtype;
  wire wr_ok = wr_good || is_store || is_restore || is_devtype;
  wire rd_ok = hit || is_fmt || is_devtype;
  wire good = link.wr ? wr_ok : rd_ok;
  wire bad = take && !good;

  logic [15:0] rd_val;
  assign rd_val = is_fmt ? {8'h00, VOUT_FMT_VAL} :
                  is_devtype ? {15'h0000, dev_lock_reg} : work_reg[slot];

  // working copy resets to factory values; nonvolatile copy holds last store
  localparam logic [15:0] FACTORY [NSLOT] = '{
    V_5P0, DEF_MARGIN_HI, DEF_MARGIN_LO, DEF_INP_ON, DEF_INP_OFF,
    DEF_CAL_GAIN, DEF_CAL_OFFSET, DEF_OV_LIMIT, DEF_OV_RESP, DEF_OC_LIMIT,
    DEF_OC_RESP, DEF_OC_WARN, DEF_OT_LIMIT, DEF_OT_RESP, DEF_OT_WARN, 16'h0000};

  genvar g;
  for (g = 0; g < NSLOT; g++) begin : g_slot
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        work_reg[g] <= FACTORY[g];
      end else if (do_restore) begin
        work_reg[g] <= nv_reg[g];
      end else if (do_write && slot == 4'(g)) begin
        work_reg[g] <= link.wdata;
      end
    end
    // flash copy survives the logic reset; calibration lives here too
    always_ff @(posedge ref_clk) begin
      if (do_store) begin
        nv_reg[g] <= work_reg[g];
      end else if (reset && !nv_valid_reg) begin
        nv_reg[g] <= FACTORY[g];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      nv_valid_reg <= 1'b1;
    end
  end

  // answer strobes last one cycle; take is masked meanwhile so a held req is not taken twice
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      nak_reg <= 1'b0;
    end else begin
      ack_reg <= take && good;
      nak_reg <= bad;
    end
  end

  // read value stands until the next read is taken
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
    end else if (take && !link.wr) begin
      rdata_reg <= rd_val;
    end
  end

  // lock bit gates calibration writes until it is cleared
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dev_lock_reg <= 1'b0;
    end else if (do_lock) begin
      dev_lock_reg <= link.wdata[0];
    end
  end

  // a new fault in the clearing cycle wins
  logic comm_fault_next;
  assign comm_fault_next = bad || (comm_fault_reg && !comm_fault_clear);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      comm_fault_reg <= 1'b0;
    end else begin
      comm_fault_reg <= comm_fault_next;
    end
  end

  // effective limit: the lower of user limit and set point + 2 V, 7 V ceiling
  logic [16:0] cap;
  assign cap = {1'b0, work_reg[SL_SETPOINT]} + {1'b0, V_2P0};
  wire [15:0] cap7 = (cap > {1'b0, V_7P0}) ? V_7P0 : cap[15:0];
  logic [15:0] ov_threshold_next;
  assign ov_threshold_next = (work_reg[SL_OV_LIMIT] > cap7) ? cap7
    : work_reg[SL_OV_LIMIT];
  logic ov_restart_next;
  logic oc_restart_next;
  logic ot_restart_next;
  assign ov_restart_next = work_reg[SL_OV_RESP][RS_HI:RS_LO] == RS_CONT;
  assign oc_restart_next = work_reg[SL_OC_RESP][RS_HI:RS_LO] == RS_CONT;
  assign ot_restart_next = work_reg[SL_OT_RESP][RS_HI:RS_LO] == RS_CONT;

  // policy outputs come from flops so the power stage never sees decode glitches
  logic [15:0] ov_threshold_reg;
  logic ov_restart_reg;
  logic oc_restart_reg;
  logic ot_restart_reg;
  always_ff @(posedge ref_clk) begin
    ov_threshold_reg <= ov_threshold_next;
    ov_restart_reg <= ov_restart_next;
    oc_restart_reg <= oc_restart_next;
    ot_restart_reg <= ot_restart_next;
  end

  assign ov_threshold = ov_threshold_reg;
  assign ov_restart_en = ov_restart_reg;
  assign oc_restart_en = oc_restart_reg;
  assign ot_restart_en = ot_restart_reg;
  assign comm_fault = comm_fault_reg;
  assign link.ack = ack_reg;
  assign link.nak = nak_reg;
  assign link.rdata = rdata_reg;
endmodule : plf_bank
`default_nettype wire

// >>> plf_pkg.sv
`default_nettype none
package plf_pkg;
  // register codes as seen on the command byte
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
  localparam logic [7:0] CMD_VOUT_FMT = 8'h20;
  localparam logic [7:0] CMD_SETPOINT = 8'h21;
  localparam logic [7:0] CMD_MARGIN_HI = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LO = 8'h26;
  localparam logic [7:0] CMD_INP_ON = 8'h35;
  localparam logic [7:0] CMD_INP_OFF = 8'h36;
  localparam logic [7:0] CMD_CAL_GAIN = 8'h38;
  localparam logic [7:0] CMD_CAL_OFFSET = 8'h39;
  localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
  localparam logic [7:0] CMD_OV_RESP = 8'h41;
  localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
  localparam logic [7:0] CMD_OC_RESP = 8'h47;
  localparam logic [7:0] CMD_OC_WARN = 8'h4A;
  localparam logic [7:0] CMD_OT_LIMIT = 8'h4F;
  localparam logic [7:0] CMD_OT_RESP = 8'h50;
  localparam logic [7:0] CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CMD_TRIM_CFG = 8'hE0;
  localparam logic [7:0] CMD_DEV_TYPE = 8'hE1;
  // storage slots of the working and nonvolatile copies
  localparam int NSLOT = 16;
  localparam logic [3:0] SL_SETPOINT = 4'h0;
  localparam logic [3:0] SL_MARGIN_HI = 4'h1;
  localparam logic [3:0] SL_MARGIN_LO = 4'h2;
  localparam logic [3:0] SL_INP_ON = 4'h3;
  localparam logic [3:0] SL_INP_OFF = 4'h4;
  localparam logic [3:0] SL_CAL_GAIN = 4'h5;
  localparam logic [3:0] SL_CAL_OFFSET = 4'h6;
  localparam logic [3:0] SL_OV_LIMIT = 4'h7;
  localparam logic [3:0] SL_OV_RESP = 4'h8;
  localparam logic [3:0] SL_OC_LIMIT = 4'h9;
  localparam logic [3:0] SL_OC_RESP = 4'hA;
  localparam logic [3:0] SL_OC_WARN = 4'hB;
  localparam logic [3:0] SL_OT_LIMIT = 4'hC;
  localparam logic [3:0] SL_OT_RESP = 4'hD;
  localparam logic [3:0] SL_OT_WARN = 4'hE;
  localparam logic [3:0] SL_TRIM_CFG = 4'hF;
  // fixed format and mantissa scaling (volts * 512)
  localparam logic [7:0] VOUT_FMT_VAL = 8'h14;
  localparam logic [15:0] V_4P0 = 16'h0800;
  localparam logic [15:0] V_5P0 = 16'h0A00;
  localparam logic [15:0] V_6P0 = 16'h0C00;
  localparam logic [15:0] V_7P0 = 16'h0E00;
  localparam logic [15:0] V_2P0 = 16'h0400;
  localparam logic [15:0] INP_ON_MIN = 16'h0020;
  localparam logic [15:0] INP_ON_MAX = 16'h0024;
  localparam logic [15:0] INP_OFF_MIN = 16'h001F;
  localparam logic [15:0] INP_OFF_MAX = 16'h0023;
  localparam logic [15:0] OC_MIN = 16'h0040;
  localparam logic [15:0] OC_MAX = 16'h0050;
  localparam logic [15:0] OTF_MIN = 16'h006E;
  localparam logic [15:0] OTW_MIN = 16'h0064;
  localparam logic [15:0] OT_MAX = 16'h007D;
  // fault-response byte fields
  localparam int RSP_HI = 7;
  localparam int RSP_LO = 6;
  localparam int RS_HI = 5;
  localparam int RS_LO = 3;
  localparam logic [1:0] RSP_SHUT = 2'h2;
  localparam logic [1:0] RSP_SHUT_OC = 2'h3;
  localparam logic [2:0] RS_NONE = 3'h0;
  localparam logic [2:0] RS_CONT = 3'h7;
  // plain defaults of values not given elsewhere
  localparam logic [15:0] DEF_MARGIN_HI = 16'h0B00;
  localparam logic [15:0] DEF_MARGIN_LO = 16'h0900;
  localparam logic [15:0] DEF_INP_ON = 16'h0022;
  localparam logic [15:0] DEF_INP_OFF = 16'h0020;
  localparam logic [15:0] DEF_CAL_GAIN = 16'h2000;
  localparam logic [15:0] DEF_CAL_OFFSET = 16'hE000;
  localparam logic [15:0] DEF_OV_LIMIT = 16'h0C00;
  localparam logic [15:0] DEF_OC_LIMIT = 16'h0048;
  localparam logic [15:0] DEF_OC_WARN = 16'h0044;
  localparam logic [15:0] DEF_OT_LIMIT = 16'h0078;
  localparam logic [15:0] DEF_OT_WARN = 16'h006E;
  localparam logic [15:0] DEF_OV_RESP = 16'h00B8;
  localparam logic [15:0] DEF_OC_RESP = 16'h00F8;
  localparam logic [15:0] DEF_OT_RESP = 16'h00B8;
  // host controller register map on Avalon-MM (byte addresses)
  localparam logic [3:0] HA_CTRL = 4'h0;
  localparam logic [3:0] HA_WDATA = 4'h4;
  localparam logic [3:0] HA_RDATA = 4'h8;
  localparam logic [3:0] HA_STATUS = 4'hC;
  localparam int CTRL_GO = 8;
  localparam int CTRL_WR = 9;
  localparam int ST_BUSY = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_DONE = 2;
endpackage : plf_pkg
`default_nettype wire

// >>> plf_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// command link between the bank and its host controller; one access at a time
interface plf_link_if;
  logic req;
  logic wr;
  logic [7:0] code;
  logic [15:0] wdata;
  logic ack;
  logic nak;
  logic [15:0] rdata;
  modport bank (input req, input wr, input code, input wdata,
                output ack, output nak, output rdata);
  modport host (output req, output wr, output code, output wdata,
                input ack, input nak, input rdata);
endinterface : plf_link_if
`default_nettype wire

// >>> plf_check.sv
`timescale 1ns/1ps
`default_nettype none
// range and cross-check of one proposed write; pure combinational
module plf_check
  import plf_pkg::*;
(
  input wire logic [3:0] slot,
  input wire logic [15:0] val,
  input wire logic [15:0] cur [NSLOT],
  output logic ok
);
  wire [16:0] ov_cap = {1'b0, cur[SL_SETPOINT]} + {1'b0, V_2P0};
  wire [7:0] rb = val[7:0];
  wire resp_ok = (rb[RS_HI:RS_LO] == RS_NONE || rb[RS_HI:RS_LO] == RS_CONT)
    && rb[2:0] == 3'h0 && val[15:8] == 8'h00;
  wire v46 = val >= V_4P0 && val <= V_6P0;
  always_comb begin
    ok = 1'b1;
    unique case (slot)
      SL_SETPOINT: ok = v46;
      SL_MARGIN_HI: ok = v46 && val > cur[SL_MARGIN_LO];
      SL_MARGIN_LO: ok = v46 && val < cur[SL_MARGIN_HI];
      SL_INP_ON: ok = val >= INP_ON_MIN && val <= INP_ON_MAX && val > cur[SL_INP_OFF];
      SL_INP_OFF: ok = val >= INP_OFF_MIN && val <= INP_OFF_MAX && val < cur[SL_INP_ON];
      SL_OV_LIMIT: ok = val >= V_5P0 && val <= V_7P0 && val > cur[SL_SETPOINT]
        && {1'b0, val} <= ov_cap;
      SL_OV_RESP: ok = resp_ok && rb[RSP_HI:RSP_LO] == RSP_SHUT;
      SL_OC_RESP: ok = resp_ok && rb[RSP_HI:RSP_LO] == RSP_SHUT_OC;
      SL_OT_RESP: ok = resp_ok && rb[RSP_HI:RSP_LO] == RSP_SHUT;
      SL_OC_LIMIT: ok = val >= OC_MIN && val <= OC_MAX && val > cur[SL_OC_WARN];
      SL_OC_WARN: ok = val >= OC_MIN && val <= OC_MAX && val < cur[SL_OC_LIMIT];
      SL_OT_LIMIT: ok = val >= OTF_MIN && val <= OT_MAX && val > cur[SL_OT_WARN];
      SL_OT_WARN: ok = val >= OTW_MIN && val <= OT_MAX && val < cur[SL_OT_LIMIT];
      SL_TRIM_CFG: ok = val[15:1] == 15'h0000;
      default: ok = 1'b1;
    endcase
  end
endmodule : plf_check
`default_nettype wire

// >>> plf_host.sv
`timescale 1ns/1ps
`default_nettype none
// host controller: software posts one access over Avalon-MM, link carries it
module plf_host
  import plf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  plf_link_if.host link
);
  import plf_pkg::*;

  typedef enum logic [0:0] {HS_IDLE = 1'b0, HS_WAIT = 1'b1} plf_hstate_t;
  plf_hstate_t st_reg;
  logic [7:0] code_reg;
  logic wr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic fault_reg;
  logic done_reg;
  logic [31:0] rd_reg;
  logic rd_pend_reg;

  // one wait cycle on every access, answered from a flop
  wire acc = (avs_read || avs_write) && !rd_pend_reg;
  // writes act only at the edge where waitrequest is seen low
  wire wacc = avs_write && rd_pend_reg;
  assign avs_waitrequest = (avs_read || avs_write) && !rd_pend_reg;
  wire busy = st_reg == HS_WAIT;
  wire go = wacc && avs_address == HA_CTRL && avs_writedata[CTRL_GO] && !busy;
  wire [31:0] rd_mux =
    avs_address == HA_CTRL ? {22'h0, wr_reg, 1'b0, code_reg} :
    avs_address == HA_WDATA ? {16'h0, wdata_reg} :
    avs_address == HA_RDATA ? {16'h0, rdata_reg} :
    avs_address == HA_STATUS ? {29'h0, done_reg, fault_reg, busy} : 32'h0;
  wire clr_status = wacc && avs_address == HA_STATUS;
  wire reply = busy && (link.ack || link.nak);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= HS_IDLE;
      code_reg <= 8'h00;
      wr_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      fault_reg <= 1'b0;
      done_reg <= 1'b0;
      rd_reg <= 32'h0;
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= acc;
      if (acc && avs_read) begin
        rd_reg <= rd_mux;
      end
      if (wacc && avs_address == HA_WDATA && !busy) begin
        wdata_reg <= avs_writedata[15:0];
      end
      if (go) begin
        code_reg <= avs_writedata[7:0];
        wr_reg <= avs_writedata[CTRL_WR];
        st_reg <= HS_WAIT;
      end else if (reply) begin
        st_reg <= HS_IDLE;
      end
      if (reply && !wr_reg && link.ack) begin
        rdata_reg <= link.rdata;
      end
      // reply sets win over software clear
      done_reg <= reply || (done_reg && !(clr_status && avs_writedata[ST_DONE]));
      fault_reg <= (reply && link.nak) || (fault_reg && !(clr_status && avs_writedata[ST_FAULT]));
    end
  end

  assign avs_readdata = rd_reg;
  // request held until the bank answers; dropped in the answer cycle
  assign link.req = busy && !(link.ack || link.nak);
  assign link.wr = wr_reg;
  assign link.code = code_reg;
  assign link.wdata = wdata_reg;
endmodule : plf_host
`default_nettype wire

// >>> plf_properties.sv
`timescale 1ns/1ps
`default_nettype none
module plf_properties
  import plf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] code,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic nak,
  input wire logic [15:0] rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // a request is taken only while no answer is out
  wire logic put = req && wr && !ack && !nak;
  wire logic get = req && !wr && !ack && !nak;
  wire logic rsp = put && (code == CMD_OV_RESP || code == CMD_OC_RESP || code == CMD_OT_RESP);
  a_one_answer: assert property (
    (put || get) |=> (ack ^ nak) ##1 (!ack && !nak)) else $error("link answer missing");
  a_format_fixed: assert property (
    put && code == CMD_VOUT_FMT |=> nak) else $error("format byte write taken");
  a_format_read: assert property (
    get && code == CMD_VOUT_FMT |=> ack && rdata[7:0] == VOUT_FMT_VAL) else $error("format value");
  a_setpoint_range: assert property (
    put && code == CMD_SETPOINT && (wdata < V_4P0 || wdata > V_6P0) |=> nak)
    else $error("set point range");
  a_margin_range: assert property (
    put && (code == CMD_MARGIN_HI || code == CMD_MARGIN_LO) && (wdata < V_4P0 || wdata > V_6P0)
    |=> nak) else $error("margin range");
  a_vin_range: assert property (
    put && ((code == CMD_INP_ON && (wdata < INP_ON_MIN || wdata > INP_ON_MAX)) ||
    (code == CMD_INP_OFF && (wdata < INP_OFF_MIN || wdata > INP_OFF_MAX))) |=> nak)
    else $error("input threshold range");
  a_ov_range: assert property (
    put && code == CMD_OV_LIMIT && (wdata < V_5P0 || wdata > V_7P0) |=> nak)
    else $error("ov limit range");
  a_ov_action: assert property (
    put && code == CMD_OV_RESP && wdata[7:6] != RSP_SHUT |=> nak) else $error("ov action bits");
  a_retry_codes: assert property (
    rsp && wdata[5:3] != RS_NONE && wdata[5:3] != RS_CONT |=> nak) else $error("retry field");
  a_no_delay: assert property (
    rsp && wdata[2:0] != 3'h0 |=> nak) else $error("delay field");
  a_oc_action: assert property (
    put && code == CMD_OC_RESP && wdata[7:6] != RSP_SHUT_OC |=> nak) else $error("oc action bits");
  a_oc_range: assert property (
    put && (code == CMD_OC_LIMIT || code == CMD_OC_WARN) && (wdata < OC_MIN || wdata > OC_MAX)
    |=> nak) else $error("oc limit range");
  a_ot_range: assert property (
    put && ((code == CMD_OT_LIMIT && (wdata < OTF_MIN || wdata > OT_MAX)) ||
    (code == CMD_OT_WARN && (wdata < OTW_MIN || wdata > OT_MAX))) |=> nak)
    else $error("ot limit range");
endmodule : plf_properties
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import plf_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, comm_fault_clear = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, comm_fault, ov_restart_en, oc_restart_en, ot_restart_en, flt;
  logic [15:0] ov_threshold, rv;
  logic [15:0] mdl [logic [7:0]];
  int error_cnt = 0;
  int n_tests = 0;
  plf_link_if u_plf_link_if ();
  plf_host u_plf_host (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(u_plf_link_if.host));
  plf_bank u_plf_bank (.ref_clk(ref_clk), .reset(reset), .link(u_plf_link_if.bank),
    .comm_fault_clear(comm_fault_clear), .comm_fault(comm_fault), .ov_threshold(ov_threshold),
    .ov_restart_en(ov_restart_en), .oc_restart_en(oc_restart_en), .ot_restart_en(ot_restart_en));
  plf_properties u_props (.ref_clk(ref_clk), .reset(reset), .req(u_plf_link_if.req),
    .wr(u_plf_link_if.wr), .code(u_plf_link_if.code), .wdata(u_plf_link_if.wdata),
    .ack(u_plf_link_if.ack), .nak(u_plf_link_if.nak), .rdata(u_plf_link_if.rdata));
  always #2.5 ref_clk = ~ref_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // one Avalon access, held until waitrequest is seen low
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : av
  task automatic link_op(input logic [7:0] c, input logic w, input logic [15:0] v,
                         output logic f, output logic [15:0] r);
    av(HA_WDATA, 1'b1, {16'h0000, v});
    av(HA_CTRL, 1'b1, {22'h0, w, 1'b1, c});
    q = 32'h0;
    while (q[ST_DONE] !== 1'b1 && q[ST_FAULT] !== 1'b1) av(HA_STATUS, 1'b0, 32'h0);
    f = q[ST_FAULT];
    av(HA_RDATA, 1'b0, 32'h0);
    r = q[15:0];
    av(HA_STATUS, 1'b1, 32'h7);
  endtask : link_op
  // write, expect refusal or not, then read back against the model if the code has an entry there
  task automatic step(input logic [7:0] c, input logic [15:0] v, input logic f);
    logic e;
    logic [15:0] r;
    link_op(c, 1'b1, v, e, r);
    check({15'h0, e}, {15'h0, f});
    if (mdl.exists(c)) begin
      if (!f) mdl[c] = v;
      link_op(c, 1'b0, 16'h0, e, r);
      check(r, mdl[c]);
    end
  endtask : step
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    mdl[CMD_SETPOINT] = V_5P0;
    mdl[CMD_MARGIN_HI] = DEF_MARGIN_HI;
    mdl[CMD_MARGIN_LO] = DEF_MARGIN_LO;
    mdl[CMD_INP_ON] = DEF_INP_ON;
    mdl[CMD_INP_OFF] = DEF_INP_OFF;
    mdl[CMD_CAL_GAIN] = DEF_CAL_GAIN;
    mdl[CMD_CAL_OFFSET] = DEF_CAL_OFFSET;
    mdl[CMD_OV_LIMIT] = DEF_OV_LIMIT;
    mdl[CMD_OV_RESP] = DEF_OV_RESP;
    mdl[CMD_OC_LIMIT] = DEF_OC_LIMIT;
    mdl[CMD_OC_RESP] = DEF_OC_RESP;
    mdl[CMD_OC_WARN] = DEF_OC_WARN;
    mdl[CMD_OT_LIMIT] = DEF_OT_LIMIT;
    mdl[CMD_OT_RESP] = DEF_OT_RESP;
    mdl[CMD_OT_WARN] = DEF_OT_WARN;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    foreach (mdl[k]) begin
      link_op(k, 1'b0, 16'h0, flt, rv);
      check(rv, mdl[k]);
    end
    link_op(CMD_VOUT_FMT, 1'b0, 16'h0, flt, rv);
    check(rv, {8'h00, VOUT_FMT_VAL});
    check(ov_threshold, V_6P0);
    check({13'h0, ov_restart_en, oc_restart_en, ot_restart_en}, 16'h7);
    step(CMD_VOUT_FMT, 16'h0014, 1'b1);
    check({15'h0, comm_fault}, 16'h1);
    comm_fault_clear <= 1'b1;
    @(posedge ref_clk);
    comm_fault_clear <= 1'b0;
    @(posedge ref_clk);
    check({15'h0, comm_fault}, 16'h0);
    step(CMD_SETPOINT, 16'h07FF, 1'b1);
    step(CMD_SETPOINT, 16'h0B00, 1'b0);
    step(CMD_MARGIN_HI, 16'h0C01, 1'b1);
    step(CMD_MARGIN_LO, 16'h0B00, 1'b1);
    step(CMD_MARGIN_LO, 16'h0800, 1'b0);
    step(CMD_MARGIN_HI, 16'h0800, 1'b1);
    step(CMD_INP_ON, 16'h0025, 1'b1);
    step(CMD_INP_OFF, 16'h0023, 1'b1);
    step(CMD_INP_OFF, 16'h001F, 1'b0);
    step(CMD_OV_LIMIT, 16'h0B00, 1'b1);
    step(CMD_OV_LIMIT, 16'h0E01, 1'b1);
    step(CMD_OV_LIMIT, 16'h0D00, 1'b0);
    step(CMD_OV_RESP, 16'h00F8, 1'b1);
    step(CMD_OV_RESP, 16'h0098, 1'b1);
    step(CMD_OV_RESP, 16'h0081, 1'b1);
    step(CMD_OV_RESP, 16'h0080, 1'b0);
    step(CMD_OC_RESP, 16'h00B8, 1'b1);
    step(CMD_OC_RESP, 16'h00C0, 1'b0);
    step(CMD_OC_LIMIT, 16'h0044, 1'b1);
    step(CMD_OC_WARN, 16'h0048, 1'b1);
    step(CMD_OC_WARN, 16'h003F, 1'b1);
    step(CMD_OC_WARN, 16'h0040, 1'b0);
    step(CMD_OC_LIMIT, 16'h0041, 1'b0);
    step(CMD_OT_LIMIT, 16'h006E, 1'b1);
    step(CMD_OT_LIMIT, 16'h007E, 1'b1);
    step(CMD_OT_WARN, 16'h0078, 1'b1);
    step(CMD_OT_WARN, 16'h0064, 1'b0);
    step(CMD_OT_LIMIT, 16'h006E, 1'b0);
    step(CMD_OT_RESP, 16'h00F8, 1'b1);
    step(CMD_OT_RESP, 16'h0080, 1'b0);
    check({13'h0, ov_restart_en, oc_restart_en, ot_restart_en}, 16'h0);
    step(CMD_TRIM_CFG, 16'h0001, 1'b0);
    step(CMD_SETPOINT, 16'h0A00, 1'b1);
    step(CMD_TRIM_CFG, 16'h0000, 1'b0);
    step(CMD_DEV_TYPE, 16'h0001, 1'b0);
    step(CMD_CAL_GAIN, 16'h1234, 1'b1);
    step(CMD_DEV_TYPE, 16'h0000, 1'b0);
    step(CMD_CAL_GAIN, 16'h1234, 1'b0);
    step(CMD_SETPOINT, 16'h0880, 1'b0);
    check(ov_threshold, 16'h0C80);
    step(CMD_STORE_ALL, 16'h0000, 1'b0);
    reset <= 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    link_op(CMD_SETPOINT, 1'b0, 16'h0, flt, rv);
    check(rv, V_5P0);
    step(CMD_RESTORE_ALL, 16'h0000, 1'b0);
    link_op(CMD_SETPOINT, 1'b0, 16'h0, flt, rv);
    check(rv, 16'h0880);
    link_op(CMD_OC_RESP, 1'b0, 16'h0, flt, rv);
    check(rv, 16'h00C0);
    link_op(CMD_CAL_GAIN, 1'b0, 16'h0, flt, rv);
    check(rv, 16'h1234);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
